/* File: core/daisy_chain_pkg.sv */
package daisy_chain_pkg;
  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_HZ = 50_000_000; // core clock rate
  localparam int CLK_PERIOD_NS = 20; // core clock period
  localparam int WD_TIMEOUT_MS = 1500; // inactivity timeout
  // longest time, rounds down
  localparam int WD_TIMEOUT_CYCLES = WD_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int ONESHOT_NS = 60; // width of forwarded clock pulse
  // least time, rounds up
  localparam int ONESHOT_CYCLES = (ONESHOT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PRI_TON_NS = 5000; // primary max on-time
  localparam int SEC_TON_NS = 2000; // secondary max on-time
  localparam int PRI_TON_CYCLES = PRI_TON_NS / CLK_PERIOD_NS;
  localparam int SEC_TON_CYCLES = SEC_TON_NS / CLK_PERIOD_NS;
  localparam int STRAP_WAIT = 3; // cycles after release before straps are caught
  localparam int CELLS = 6; // balancers per device

  // ------------------------------------------------------------
  // synchroniser lanes
  // ------------------------------------------------------------
  localparam int SY_CS = 0;
  localparam int SY_SCK = 1;
  localparam int SY_SDI = 2;
  localparam int SY_UP = 3;
  localparam int SY_WD = 4;
  localparam int SY_TOS = 5;
  localparam int SY_LVL = 6;
  localparam int SY_TOPO = 7;
  localparam int SY_BOOST = 8;
  localparam int SY_PRI_DEF = 9;
  localparam int SY_SEC_DEF = 10;
  localparam int SY_W = 11;
  localparam logic [10:0] SYNC_RST = 11'h001; // chip select idles high

  // ------------------------------------------------------------
  // watchdog states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    WD_RELEASED = 2'b00,
    WD_ACTIVE = 2'b01,
    WD_EXPIRED = 2'b10
  } wd_state_t;
endpackage

/* File: core/ontime_limiter.sv */
module ontime_limiter
  import daisy_chain_pkg::*;
#(
  parameter int MAX_CYCLES = 100,
  parameter int CNT_W = 16
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  input wire logic req_i,
  input wire logic enable_i,
  input wire logic defeat_i,
  output logic gate_o
);
  // ------------------------------------------------------------
  // on-time counting
  // ------------------------------------------------------------
  localparam logic [CNT_W-1:0] MAX_C = CNT_W'(MAX_CYCLES); // limit at counter width
  logic [CNT_W-1:0] run; // cycles the gate has been high
  logic locked; // limit hit, held until request drops
  // stop one count early: the gate flop adds a cycle after the compare
  wire at_limit = gate_o && (run >= MAX_C - CNT_W'(1)) && !defeat_i;
  wire next_gate = req_i && enable_i && !locked && !at_limit;
  wire run_sat = &run;

  // gate with max on-time clamp
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      gate_o <= 1'b0;
      run <= '0;
      locked <= 1'b0;
    end else begin
      gate_o <= next_gate;
      run <= gate_o ? (run_sat ? run : run + 1'b1) : '0;
      locked <= req_i && (locked || at_limit);
    end
  end

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  ontime_clamp_a: assert property (gate_o && !defeat_i |-> run < MAX_C)
    else $error("gate held past its max on-time");
  clamp_hold_a: assert property (locked && req_i |=> !gate_o)
    else $error("gate re-fired before request dropped");
endmodule

/* File: core/daisy_chain_serial_port_watchdog.sv */
// What this block does
// - watchdog goes high after 1.5 s idle
// - watchdog high keeps all balancers off
// - watchdog released at power-up and idle
// - watchdog pulled low while balancing or talking
// - watchdog pin strapped low disables timer
// - forward one-shot clock while select low
// - forward buffered chip select upward
// - up data pin: out on write, in on read
// - top of chain ignores up data pin
// - non-top passes data through up pin
// - level mode high: pins are voltage logic
// - level mode low: down data unused
// - down read data is open-drain pull-down
// - topology strap picks single or multi transformer
// - single transformer uses only first secondary gate
// - secondary gate on-time limited unless defeated
// - primary gate on-time limited unless defeated
// - boosted drive only when boost strap high
module daisy_chain_serial_port_watchdog
  import daisy_chain_pkg::*;
#(
  parameter int TIMEOUT_CYCLES = WD_TIMEOUT_CYCLES,
  parameter int PRI_MAX = PRI_TON_CYCLES,
  parameter int SEC_MAX = SEC_TON_CYCLES
) (
  input wire logic core_clk_i,
  input wire logic reset_n_i,
  // chain pins, asynchronous
  input wire logic chain_select_in_i,
  input wire logic chain_clock_in_i,
  input wire logic chain_data_in_i,
  input wire logic chain_data_up_bidir_i,
  output logic chain_data_up_bidir_o,
  output logic chain_data_up_bidir_oe_o,
  output logic chain_select_out_o,
  output logic chain_clock_out_o,
  output logic chain_data_out_down_o,
  output logic chain_data_out_down_oe_o,
  // open-drain watchdog pin
  input wire logic watchdog_out_i,
  output logic watchdog_out_o,
  output logic watchdog_out_oe_o,
  // strap pins
  input wire logic top_of_chain_strap_i,
  input wire logic level_mode_strap_i,
  input wire logic single_transformer_strap_i,
  input wire logic boost_enable_strap_i,
  input wire logic primary_ontime_prog_at_reg_i,
  input wire logic secondary_ontime_prog_at_reg_i,
  // command decoder side, same clock
  input wire logic cmd_byte_valid_i,
  input wire logic balance_active_i,
  input wire logic read_active_i,
  input wire logic read_bit_i,
  output logic rx_bit_o,
  output logic rx_strobe_o,
  // gate drive requests and outputs
  input wire logic [CELLS-1:0] primary_gate_req_i,
  input wire logic [CELLS-1:0] secondary_gate_req_i,
  output logic [CELLS-1:0] primary_gate_o,
  output logic [CELLS-1:0] secondary_gate_o,
  output logic boost_drive_en_o
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  localparam int WD_W = $clog2(TIMEOUT_CYCLES + 1); // timer width
  localparam logic [WD_W-1:0] WD_LAST = WD_W'(TIMEOUT_CYCLES - 1); // final count
  localparam logic [3:0] OS_LEN = 4'(ONESHOT_CYCLES); // one-shot length
  localparam logic [1:0] STRAP_AT = 2'(STRAP_WAIT); // strap catch point

  logic [SY_W-1:0] sync_a; // first stage, read only by sync_b
  logic [SY_W-1:0] sync_b; // second stage, safe to use
  wire [SY_W-1:0] pin_raw = {secondary_ontime_prog_at_reg_i, primary_ontime_prog_at_reg_i,
                             boost_enable_strap_i, single_transformer_strap_i,
                             level_mode_strap_i, top_of_chain_strap_i, watchdog_out_i,
                             chain_data_up_bidir_i, chain_data_in_i, chain_clock_in_i,
                             chain_select_in_i};

  // two flops on every asynchronous pin
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync_a <= SYNC_RST;
      sync_b <= SYNC_RST;
    end else begin
      sync_a <= pin_raw;
      sync_b <= sync_a;
    end
  end

  wire cs_s = sync_b[SY_CS]; // select, active low
  wire sck_s = sync_b[SY_SCK]; // serial clock
  wire sdi_s = sync_b[SY_SDI]; // data from below
  wire up_s = sync_b[SY_UP]; // data from above

  // ------------------------------------------------------------
  // strap capture after reset release
  // ------------------------------------------------------------
  logic [1:0] strap_cnt; // wait for synchronisers to fill
  logic straps_taken; // straps valid
  logic top_of_chain; // this device ends the chain
  logic voltage_mode; // rail-to-rail pins
  logic single_tx; // one shared transformer
  logic boost_en; // boosted top-cell drive
  logic pri_defeat; // primary on-time limit off
  logic sec_defeat; // secondary on-time limit off
  logic wd_disabled; // watchdog pin strapped low
  wire strap_now = !straps_taken && (strap_cnt == STRAP_AT);

  // count to the catch point
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      strap_cnt <= 2'h0;
      straps_taken <= 1'b0;
    end else begin
      strap_cnt <= straps_taken ? strap_cnt : strap_cnt + 2'h1;
      straps_taken <= straps_taken || strap_now;
    end
  end

  // latch the straps once, released pins only
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      top_of_chain <= 1'b0;
      voltage_mode <= 1'b0;
      single_tx <= 1'b0;
      boost_en <= 1'b0;
      pri_defeat <= 1'b0;
      sec_defeat <= 1'b0;
      wd_disabled <= 1'b0;
    end else if (strap_now) begin
      top_of_chain <= sync_b[SY_TOS];
      voltage_mode <= sync_b[SY_LVL];
      single_tx <= sync_b[SY_TOPO];
      boost_en <= sync_b[SY_BOOST];
      pri_defeat <= sync_b[SY_PRI_DEF];
      sec_defeat <= sync_b[SY_SEC_DEF];
      wd_disabled <= !sync_b[SY_WD];
    end
  end

  // ------------------------------------------------------------
  // serial clock edges and chain forwarding
  // ------------------------------------------------------------
  logic sck_d; // previous clock level
  logic [3:0] os_cnt; // one-shot remaining
  wire sck_rise = sck_s && !sck_d;
  wire fire = sck_rise && !cs_s;
  wire [3:0] next_os = fire ? OS_LEN : (os_cnt != 4'h0 ? os_cnt - 4'h1 : 4'h0);

  // edge detect and one-shot
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sck_d <= 1'b0;
      os_cnt <= 4'h0;
      chain_clock_out_o <= 1'b0;
      chain_select_out_o <= 1'b1;
    end else begin
      sck_d <= sck_s;
      os_cnt <= next_os;
      chain_clock_out_o <= next_os != 4'h0;
      chain_select_out_o <= cs_s;
    end
  end

  // bits handed to the command decoder
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rx_bit_o <= 1'b0;
      rx_strobe_o <= 1'b0;
    end else begin
      rx_bit_o <= fire ? sdi_s : rx_bit_o;
      rx_strobe_o <= fire;
    end
  end

  // ------------------------------------------------------------
  // data pins up and down
  // ------------------------------------------------------------
  wire selected = !cs_s && straps_taken;
  wire up_drive = selected && !top_of_chain && !read_active_i;
  wire down_bit = top_of_chain ? read_bit_i : up_s;
  wire down_pull = selected && voltage_mode && read_active_i && !down_bit;

  // write data goes up, read data comes down
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      chain_data_up_bidir_o <= 1'b0;
      chain_data_up_bidir_oe_o <= 1'b0;
      chain_data_out_down_o <= 1'b0;
      chain_data_out_down_oe_o <= 1'b0;
    end else begin
      chain_data_up_bidir_o <= sdi_s;
      chain_data_up_bidir_oe_o <= up_drive;
      chain_data_out_down_o <= 1'b0;
      chain_data_out_down_oe_o <= down_pull;
    end
  end

  // ------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------
  wd_state_t wd_state;
  wd_state_t next_wd_state;
  logic [WD_W-1:0] wd_count; // cycles since last valid byte
  wire activity = cmd_byte_valid_i || selected;
  wire wd_done = (wd_count == WD_LAST) && !cmd_byte_valid_i && !wd_disabled;
  wire busy = balance_active_i || selected;

  // state selection
  always_comb begin
    next_wd_state = wd_state;
    unique case (wd_state)
      WD_RELEASED: begin
        if (activity && straps_taken) next_wd_state = WD_ACTIVE;
      end
      WD_ACTIVE: begin
        if (wd_done) next_wd_state = WD_EXPIRED;
        else if (!busy && !cmd_byte_valid_i) next_wd_state = WD_RELEASED;
      end
      WD_EXPIRED: begin
        if (activity) next_wd_state = WD_ACTIVE;
      end
      default: next_wd_state = WD_RELEASED;
    endcase
  end

  wire wd_high = (next_wd_state != WD_ACTIVE) && !wd_disabled;
  wire next_pull = (next_wd_state == WD_ACTIVE);

  // state, timer and pin
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      wd_state <= WD_RELEASED;
      wd_count <= '0;
      watchdog_out_o <= 1'b0;
      watchdog_out_oe_o <= 1'b0;
    end else begin
      wd_state <= next_wd_state;
      wd_count <= (cmd_byte_valid_i || wd_state != WD_ACTIVE) ? '0 : wd_count + 1'b1;
      watchdog_out_o <= 1'b0;
      watchdog_out_oe_o <= next_pull;
    end
  end

  // ------------------------------------------------------------
  // gate drive
  // ------------------------------------------------------------
  wire gates_ok = straps_taken && !wd_high && balance_active_i;
  wire [CELLS-1:0] sec_use = single_tx ? CELLS'(1) : {CELLS{1'b1}};

  genvar g;
  generate
    for (g = 0; g < CELLS; g++) begin : gate_lane
      ontime_limiter #(.MAX_CYCLES(PRI_MAX)) pri_lim (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .req_i(primary_gate_req_i[g]),
        .enable_i(gates_ok),
        .defeat_i(pri_defeat),
        .gate_o(primary_gate_o[g])
      );
      ontime_limiter #(.MAX_CYCLES(SEC_MAX)) sec_lim (
        .core_clk_i(core_clk_i),
        .reset_n_i(reset_n_i),
        .req_i(secondary_gate_req_i[g]),
        .enable_i(gates_ok && sec_use[g]),
        .defeat_i(sec_defeat),
        .gate_o(secondary_gate_o[g])
      );
    end
  endgenerate

  // boost only with the strap
  always_ff @(posedge core_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) boost_drive_en_o <= 1'b0;
    else boost_drive_en_o <= boost_en;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence last_tick_s;
    wd_state == WD_ACTIVE && wd_count == WD_LAST && !cmd_byte_valid_i && !wd_disabled;
  endsequence

  wd_expire_a: assert property (last_tick_s |=> !watchdog_out_oe_o)
    else $error("watchdog did not expire at timeout");
  wd_gates_a: assert property (wd_state == WD_EXPIRED |->
      primary_gate_o == '0 && secondary_gate_o == '0)
    else $error("gate on while watchdog high");
  // a released watchdog blocks every gate from the next edge on
  wd_gate_block_a: assert property (wd_high |=>
      primary_gate_o == '0 && secondary_gate_o == '0)
    else $error("gate fired while watchdog released");
  wd_release_a: assert property (wd_state != WD_ACTIVE |-> !watchdog_out_oe_o)
    else $error("watchdog pulled while idle");
  wd_pull_a: assert property (cmd_byte_valid_i && straps_taken |=> watchdog_out_oe_o)
    else $error("watchdog not pulled after valid byte");
  wd_strap_a: assert property (wd_disabled |-> wd_state != WD_EXPIRED)
    else $error("disabled watchdog expired");
  clk_fwd_a: assert property (fire |=> chain_clock_out_o [*3])
    else $error("forwarded clock pulse too short");
  cs_fwd_a: assert property (##1 chain_select_out_o == $past(cs_s))
    else $error("select not forwarded");
  top_ignore_a: assert property (top_of_chain |-> !chain_data_up_bidir_oe_o)
    else $error("top device drove up data");
  down_od_a: assert property (!chain_data_out_down_o)
    else $error("down data driven high");
  current_quiet_a: assert property (!voltage_mode |-> !chain_data_out_down_oe_o)
    else $error("down data pulled in current mode");
  single_tx_a: assert property (single_tx |-> secondary_gate_o[CELLS-1:1] == '0)
    else $error("unused secondary gate fired");
  wd_restart_a: assert property (cmd_byte_valid_i |=> wd_count == '0)
    else $error("timer not restarted by valid byte");

  // one forwarded edge: three cycles high, then low again
  sequence fwd_edge_s;
    fire;
  endsequence
  sequence fwd_pulse_s;
    chain_clock_out_o [*3] ##1 !chain_clock_out_o;
  endsequence

  clk_shape_a: assert property (fwd_edge_s |=> fwd_pulse_s)
    else $error("forwarded clock pulse has wrong shape");
  rx_pair_a: assert property (fire |=> rx_strobe_o && rx_bit_o == $past(sdi_s))
    else $error("sampled bit not handed on");
  up_fwd_a: assert property (selected && !top_of_chain && !read_active_i |=>
      chain_data_up_bidir_oe_o && chain_data_up_bidir_o == $past(sdi_s))
    else $error("write data not passed upward");
  read_no_up_a: assert property (read_active_i |=> !chain_data_up_bidir_oe_o)
    else $error("up data driven during a read");
  down_read_a: assert property (selected && voltage_mode && read_active_i &&
      !down_bit |=> chain_data_out_down_oe_o)
    else $error("read zero not pulled down");
  boost_strap_a: assert property (!boost_en |-> !boost_drive_en_o)
    else $error("boost drive without strap");
  // no gate and no watchdog pull may act before the straps are caught
  pre_strap_a: assert property (!straps_taken |-> !watchdog_out_oe_o &&
      primary_gate_o == '0 && secondary_gate_o == '0)
    else $error("output active before straps caught");
endmodule

/* File: verif/chain_host_model.sv */
// -------------------------------------------
// host side of the chain, bottom of stack
// -------------------------------------------
module chain_host_model (
  input wire logic core_clk_i,
  output logic select_n_o,
  output logic sck_o,
  output logic sdi_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // idle: deselected, link clock parked low
  initial begin
    select_n_o = 1'b1;
    sck_o = 1'b0;
    sdi_o = 1'b0;
  end
  // one frame, msb first, 160 ns per link clock
  task automatic send(input logic [7:0] value);
    @(posedge core_clk_i);
    select_n_o <= 1'b0;
    for (int i = 7; i >= 0; i--) begin
      sdi_o <= value[i];
      repeat (4) @(posedge core_clk_i);
      sck_o <= 1'b1;
      repeat (4) @(posedge core_clk_i);
      sck_o <= 1'b0;
    end
    repeat (4) @(posedge core_clk_i);
    select_n_o <= 1'b1;
    sdi_o <= ~value[0]; // released line shows no stale bit
  endtask
endmodule

/* File: verif/tb_top.sv */
module tb_top import daisy_chain_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  // -------------------------------------------
  // signals
  // -------------------------------------------
  localparam int TMO = 200; // shortened watchdog span
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic sel_n, sck, chain_data_in, up_pin, up_bit, wd_pin, wd_tie;
  logic top, lvl, single, boost, pdef, sdef, byte_ok, bal, rd, rd_bit;
  logic [5:0] preq, sreq, pgate, sgate;
  logic up_o, up_oe, sel_o, sck_fwd, down_o, down_oe, wd_o, wd_oe;
  logic rx_bit, rx_stb, boost_en, exp_bit;
  logic bq[$]; // bits sent, in order
  int err_count, checked, seed, run, rises;
  // wire levels of the two-way and open-drain pins
  assign up_pin = up_oe ? up_o : up_bit;
  assign wd_pin = wd_tie ? 1'b0 : (wd_oe ? wd_o : 1'b1);
  always #10 clk = ~clk;
  chain_host_model u_host (.core_clk_i(clk), .select_n_o(sel_n), .sck_o(sck), .sdi_o(chain_data_in));
  daisy_chain_serial_port_watchdog #(.TIMEOUT_CYCLES(TMO), .PRI_MAX(12), .SEC_MAX(8)) u_dut (
    .core_clk_i(clk), .reset_n_i(rst_n),
    .chain_select_in_i(sel_n), .chain_clock_in_i(sck), .chain_data_in_i(chain_data_in),
    .chain_data_up_bidir_i(up_pin), .chain_data_up_bidir_o(up_o),
    .chain_data_up_bidir_oe_o(up_oe), .chain_select_out_o(sel_o),
    .chain_clock_out_o(sck_fwd), .chain_data_out_down_o(down_o),
    .chain_data_out_down_oe_o(down_oe), .watchdog_out_i(wd_pin),
    .watchdog_out_o(wd_o), .watchdog_out_oe_o(wd_oe),
    .top_of_chain_strap_i(top), .level_mode_strap_i(lvl),
    .single_transformer_strap_i(single), .boost_enable_strap_i(boost),
    .primary_ontime_prog_at_reg_i(pdef), .secondary_ontime_prog_at_reg_i(sdef),
    .cmd_byte_valid_i(byte_ok), .balance_active_i(bal), .read_active_i(rd),
    .read_bit_i(rd_bit), .rx_bit_o(rx_bit), .rx_strobe_o(rx_stb),
    .primary_gate_req_i(preq), .secondary_gate_req_i(sreq),
    .primary_gate_o(pgate), .secondary_gate_o(sgate), .boost_drive_en_o(boost_en));
  // -------------------------------------------
  // compare and verdict
  // -------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("mismatches=%0d compares=%0d", err_count, checked);
    if (err_count == 0 && checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // forwarded clock pulse width and sampled bits
  always @(posedge clk) begin
    if (sck_fwd === 1'b1) run <= run + 1;
    else if (run != 0) begin
      check(32'(run), ONESHOT_CYCLES);
      rises <= rises + 1;
      run <= 0;
    end
    if (rx_stb === 1'b1) begin
      exp_bit = bq.pop_front();
      check(32'(rx_bit), 32'(exp_bit));
      if (!top && !rd) check(32'(up_o), 32'(exp_bit));
    end
  end
  // hang guard
  initial begin
    repeat (20000) @(posedge clk);
    err_count++;
    report_and_stop();
  end
  // -------------------------------------------
  // main sequence: pass 0 bottom device, passes 1 and 2 top, 2 in current mode
  // -------------------------------------------
  initial begin
    logic [7:0] b;
    logic hi;
    seed = 32'h76B2;
    {up_bit, wd_tie, top, lvl, single, boost, pdef, sdef} = 8'h00;
    {byte_ok, bal, rd, rd_bit, preq, sreq} = 16'h0000;
    for (int p = 0; p < 3; p++) begin
      // reset with this pass's straps
      hi = (p != 0);
      @(posedge clk);
      rst_n <= 1'b0;
      {top, single, pdef, sdef, wd_tie} <= {5{hi}};
      boost <= !hi;
      lvl <= (p != 2);
      repeat (2) @(posedge clk);
      check(32'(sel_o), 1);
      check(32'(wd_oe), 0);
      repeat (18) @(posedge clk);
      rst_n <= 1'b1;
      repeat (12) @(posedge clk);
      check(32'(boost_en), 32'(!hi));
      // write frame then read frame
      for (int f = 0; f < 2; f++) begin
        b = 8'($random(seed));
        rd <= f[0];
        up_bit <= 1'($random(seed));
        rd_bit <= 1'($random(seed));
        for (int i = 7; i >= 0; i--) bq.push_back(b[i]);
        fork
          u_host.send(b);
          begin
            repeat (30) @(posedge clk);
            check(32'(sel_o), 0);
            check(32'(up_oe), 32'(!hi && !f[0]));
            check(32'(down_oe), 32'(f[0] && lvl && !(hi ? rd_bit : up_bit)));
            check(32'(down_o), 0);
            check(32'(wd_oe), 1);
            check(32'(wd_o), 0);
          end
        join
      end
      repeat (10) @(posedge clk);
      check(32'(rises), 32'(16 * (p + 1)));
      check(32'(sel_o), 1);
      check(32'(wd_oe), 0);
      // balance with gate requests
      preq <= 6'($random(seed)) | 6'h01;
      sreq <= 6'($random(seed)) | 6'h03;
      bal <= 1'b1;
      byte_ok <= 1'b1;
      @(posedge clk);
      byte_ok <= 1'b0;
      repeat (4) @(posedge clk);
      check(32'(wd_oe), 1);
      check(32'(pgate), 32'(preq));
      check(32'(sgate), 32'(hi ? (sreq & 6'h01) : sreq));
      repeat (150) @(posedge clk);
      byte_ok <= 1'b1;
      @(posedge clk);
      byte_ok <= 1'b0;
      repeat (150) @(posedge clk);
      check(32'(wd_oe), 1);
      check(32'(pgate), 32'(hi ? preq : 6'h00));
      check(32'(sgate), 32'(hi ? (sreq & 6'h01) : 6'h00));
      repeat (TMO) @(posedge clk);
      check(32'(wd_oe), 32'(hi));
      // re-request after expiry: still blocked unless watchdog disabled
      preq <= 6'h00;
      repeat (2) @(posedge clk);
      preq <= 6'h3F;
      repeat (4) @(posedge clk);
      check(32'(pgate), 32'(hi ? 6'h3F : 6'h00));
      {bal, preq, sreq} <= 13'h0000;
    end
    report_and_stop();
  end
endmodule
